// ==== rtl/lcacd_ctrl.sv ====
// Controller that frames user commands onto the two-edge command bus
`timescale 1ns/1ns
`default_nettype none
module lcacd_ctrl #(
  parameter int MR_GAP     = lcacd_pkg::MR_GAP_CYC,
  parameter int RESET_HOLD = lcacd_pkg::RESET_HOLD_CYC
) (
  // Clock and reset
  input  wire logic                   I_CORE_CLK,
  input  wire logic                   I_RESETN,
  // User command request
  input  wire logic                   I_CMD_VALID,
  input  wire lcacd_pkg::lcacd_kind_e I_CMD_KIND,
  input  wire logic [2:0]             I_BANK,
  input  wire logic [16:0]            I_ROW,
  input  wire logic [9:0]             I_COL,
  input  wire logic [5:0]             I_MR_ADDR,
  input  wire logic [7:0]             I_OP,
  input  wire logic                   I_ALL_BANK,
  input  wire logic                   I_BL32,
  input  wire logic                   I_AUTO_PRE,
  input  wire logic                   I_MPC_CAS,
  output logic                        O_CMD_READY,
  output logic                        O_CMD_REFUSED,
  // Device recovery
  input  wire logic                   I_RESET_REQ,
  input  wire logic                   I_INIT_DONE,
  output logic                        O_INIT_REQ,
  // Device pins
  output logic                        O_CS,
  output logic [5:0]                  O_CA,
  output logic                        O_CKE,
  output logic                        O_DEV_RESET_N
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RESET,
    ST_IDLE,
    ST_SEND,
    ST_GAP
  } lcacd_state_e;

  lcacd_state_e state_q;          // Sequencer state
  logic [5:0]   seq_q [4];        // Lane words to send
  logic [1:0]   last_q;           // Index of last word
  logic [1:0]   idx_q;            // Word being sent
  logic         mr_q;             // Sequence is a mode access
  logic [15:0]  cnt_q;            // Reset and gap counter
  logic         cs_q;             // Chip select pin
  logic [5:0]   ca_q;             // Lane pins
  logic         rst_pin_q;        // Device reset pin level
  logic         init_q;           // Init sequence owed
  logic         refused_q;        // Refusal pulse
  logic [5:0]   w_d [4];          // Built words
  logic [1:0]   last_d;           // Built last index
  logic         mr_d;             // Built mode flag
  logic         bad_addr;         // Forbidden mode address
  logic         accept;           // Request taken
  logic [7:0]   since_mr_q;       // Cycles since mode access ended

  assign O_CMD_READY   = (state_q == ST_IDLE) && !I_RESET_REQ;
  assign O_CMD_REFUSED = refused_q;
  assign O_INIT_REQ    = init_q;
  assign O_CS          = cs_q;
  assign O_CA          = ca_q;
  assign O_CKE         = rst_pin_q;
  assign O_DEV_RESET_N = rst_pin_q;

  // ----------------------------------------------------------------
  // Request screening
  // ----------------------------------------------------------------
  // Forbidden and future mode addresses refused outright
  assign bad_addr = ((I_CMD_KIND == lcacd_pkg::K_MODE_WRITE) ||
                     (I_CMD_KIND == lcacd_pkg::K_MODE_READ)) &&
                    (I_MR_ADDR >= lcacd_pkg::MR_DO_NOT_USE_FIRST);
  assign accept   = O_CMD_READY && I_CMD_VALID && !bad_addr;

  // ----------------------------------------------------------------
  // Lane word builder
  // ----------------------------------------------------------------
  // Words 0/1 form the first command, 2/3 the follow-on half
  always_comb begin
    w_d[0] = 6'h00;
    w_d[1] = 6'h00;
    w_d[2] = {I_COL[8], lcacd_pkg::CODE_CAS_2};
    w_d[3] = I_COL[7:2];
    last_d = 2'h1;
    mr_d   = 1'b0;
    case (I_CMD_KIND)
      // Mode write, both halves back to back
      lcacd_pkg::K_MODE_WRITE: begin
        w_d[0] = {I_OP[7], lcacd_pkg::CODE_MODE_WR_1};
        w_d[1] = I_MR_ADDR;
        w_d[2] = {I_OP[6], lcacd_pkg::CODE_MODE_WR_2};
        w_d[3] = I_OP[5:0];
        last_d = 2'h3;
        mr_d   = 1'b1;
      end
      // Mode read, then column second half
      lcacd_pkg::K_MODE_READ: begin
        w_d[0] = {1'b0, lcacd_pkg::CODE_MODE_RD_1};
        w_d[1] = I_MR_ADDR;
        last_d = 2'h3;
        mr_d   = 1'b1;
      end
      // Refresh with all-bank flag
      lcacd_pkg::K_REFRESH: begin
        w_d[0] = {I_ALL_BANK, lcacd_pkg::CODE_REFRESH};
        w_d[1] = {3'h0, I_BANK};
      end
      // Precharge with all-bank flag
      lcacd_pkg::K_PRECHARGE: begin
        w_d[0] = {I_ALL_BANK, lcacd_pkg::CODE_PRECHARGE};
        w_d[1] = {3'h0, I_BANK};
      end
      // Self-refresh entry
      lcacd_pkg::K_SR_ENTER: begin
        w_d[0] = {1'b0, lcacd_pkg::CODE_SR_ENTER};
      end
      // Self-refresh exit
      lcacd_pkg::K_SR_EXIT: begin
        w_d[0] = {1'b0, lcacd_pkg::CODE_SR_EXIT};
      end
      // Activate, two halves back to back
      lcacd_pkg::K_ACTIVATE: begin
        w_d[0] = {I_ROW[15:12], lcacd_pkg::CODE_ACT_1};
        w_d[1] = {I_ROW[11], I_ROW[10], I_ROW[16], I_BANK};
        w_d[2] = {I_ROW[9:6], lcacd_pkg::CODE_ACT_2};
        w_d[3] = I_ROW[5:0];
        last_d = 2'h3;
      end
      // Write, column bits 3 and 2 forced low
      lcacd_pkg::K_WRITE: begin
        w_d[0] = {I_BL32, lcacd_pkg::CODE_WRITE_1};
        w_d[1] = {I_AUTO_PRE, I_COL[9], 1'b0, I_BANK};
        w_d[3] = {I_COL[7:4], 2'b00};
        last_d = 2'h3;
      end
      // Masked write, burst 16 only
      lcacd_pkg::K_MASK_WRITE: begin
        w_d[0] = {1'b0, lcacd_pkg::CODE_MWRITE_1};
        w_d[1] = {I_AUTO_PRE, I_COL[9], 1'b0, I_BANK};
        w_d[3] = {I_COL[7:4], 2'b00};
        last_d = 2'h3;
      end
      // Read
      lcacd_pkg::K_READ: begin
        w_d[0] = {I_BL32, lcacd_pkg::CODE_READ_1};
        w_d[1] = {I_AUTO_PRE, I_COL[9], 1'b0, I_BANK};
        last_d = 2'h3;
      end
      // Multipurpose, training forms add a column half
      default: begin
        w_d[0] = {I_OP[6], lcacd_pkg::CODE_MPC};
        w_d[1] = I_OP[5:0];
        last_d = I_MPC_CAS ? 2'h3 : 2'h1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Reset pin hold, word issue and post mode access spacing
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RESETN) begin
      state_q   <= ST_RESET;
      cnt_q     <= 16'h0000;
      idx_q     <= 2'h0;
      last_q    <= 2'h1;
      mr_q      <= 1'b0;
      rst_pin_q <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        seq_q[i] <= 6'h00;
      end
    end else if (I_RESET_REQ) begin
      // Recovery after an illegal event
      state_q   <= ST_RESET;
      cnt_q     <= 16'h0000;
      rst_pin_q <= 1'b0;
    end else begin
      case (state_q)
        // Hold device reset pin low
        ST_RESET: begin
          cnt_q <= cnt_q + 16'h0001;
          if (cnt_q == 16'(RESET_HOLD - 1)) begin
            rst_pin_q <= 1'b1;
            state_q   <= ST_IDLE;
          end
        end
        // Wait for a request
        ST_IDLE: begin
          if (accept) begin
            seq_q   <= w_d;
            last_q  <= last_d;
            mr_q    <= mr_d;
            idx_q   <= 2'h0;
            state_q <= ST_SEND;
          end
        end
        // Issue one lane word a cycle, no gaps
        ST_SEND: begin
          idx_q <= idx_q + 2'h1;
          if (idx_q == last_q) begin
            cnt_q   <= 16'h0000;
            state_q <= mr_q ? ST_GAP : ST_IDLE;
          end
        end
        // Spacing after mode access
        default: begin
          cnt_q <= cnt_q + 16'h0001;
          if (cnt_q >= 16'(MR_GAP - 1)) begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin registers
  // ----------------------------------------------------------------
  // Chip select high on even words, low on odd; low when idle
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RESETN) begin
      cs_q <= 1'b0;
      ca_q <= 6'h00;
    end else if ((state_q == ST_SEND) && !I_RESET_REQ) begin
      cs_q <= !idx_q[0];
      ca_q <= seq_q[idx_q];
    end else begin
      cs_q <= 1'b0;
      ca_q <= 6'h00;
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  // Refusal pulse and init-owed flag; setting wins over done
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RESETN) begin
      refused_q <= 1'b0;
      init_q    <= 1'b1;
    end else begin
      refused_q <= O_CMD_READY && I_CMD_VALID && bad_addr;
      if (I_RESET_REQ) begin
        init_q <= 1'b1;
      end else if (I_INIT_DONE) begin
        init_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Cycles since the last mode access finished on the pins
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RESETN) begin
      since_mr_q <= 8'hff;
    end else if ((state_q == ST_SEND) && mr_q) begin
      since_mr_q <= 8'h00;
    end else if (since_mr_q != 8'hff) begin
      since_mr_q <= since_mr_q + 8'h01;
    end
  end

  chk_cs_two_edge: assert property (@(posedge I_CORE_CLK)
    disable iff (!I_RESETN) O_CS |=> !O_CS)
    else $error("chip select held high on second edge");

  chk_cke_high: assert property (@(posedge I_CORE_CLK)
    disable iff (!I_RESETN) O_CS |-> O_CKE)
    else $error("command issued with clock enable low");

  chk_no_bad_addr: assert property (@(posedge I_CORE_CLK)
    disable iff (!I_RESETN)
    (O_CS && ((O_CA[4:0] == lcacd_pkg::CODE_MODE_WR_1) ||
              (O_CA[4:0] == lcacd_pkg::CODE_MODE_RD_1)))
    |=> (O_CA < lcacd_pkg::MR_DO_NOT_USE_FIRST))
    else $error("forbidden mode register address driven");

  chk_mrw_pair: assert property (@(posedge I_CORE_CLK)
    disable iff (!I_RESETN)
    (O_CS && (O_CA[4:0] == lcacd_pkg::CODE_MODE_WR_1))
    |-> ##2 (O_CS && (O_CA[4:0] == lcacd_pkg::CODE_MODE_WR_2)))
    else $error("mode write second half not immediate");

  chk_cas_follow: assert property (@(posedge I_CORE_CLK)
    disable iff (!I_RESETN)
    (O_CS && ((O_CA[4:0] == lcacd_pkg::CODE_READ_1) ||
              (O_CA[4:0] == lcacd_pkg::CODE_MODE_RD_1)))
    |-> ##2 (O_CS && (O_CA[4:0] == lcacd_pkg::CODE_CAS_2)))
    else $error("column second half not immediate");

  chk_wr_c32_low: assert property (@(posedge I_CORE_CLK)
    disable iff (!I_RESETN)
    (O_CS && ((O_CA[4:0] == lcacd_pkg::CODE_WRITE_1) ||
              (O_CA[4:0] == lcacd_pkg::CODE_MWRITE_1)))
    |-> ##3 (O_CA[1:0] == 2'b00))
    else $error("write column bits 3 and 2 not low");

  chk_act_pair: assert property (@(posedge I_CORE_CLK)
    disable iff (!I_RESETN)
    (O_CS && (O_CA[1:0] == lcacd_pkg::CODE_ACT_1) && $rose(O_CS)
     && (state_q == ST_SEND) && (idx_q == 2'h1) && (last_q == 2'h3)
     && (seq_q[0][1:0] == lcacd_pkg::CODE_ACT_1))
    |-> ##2 (O_CS && (O_CA[1:0] == lcacd_pkg::CODE_ACT_2)))
    else $error("activate second half not immediate");

  chk_mr_gap: assert property (@(posedge I_CORE_CLK)
    disable iff (!I_RESETN)
    (O_CS && (since_mr_q != 8'hff) && (since_mr_q > 8'h01))
    |-> (since_mr_q > 8'(MR_GAP)))
    else $error("mode access spacing violated");

  chk_reset_hold: assert property (@(posedge I_CORE_CLK)
    disable iff (!I_RESETN)
    I_RESET_REQ |=> (!O_DEV_RESET_N && O_INIT_REQ && !O_CS))
    else $error("reset request did not reset device");

endmodule
`default_nettype wire

// ==== common/lcacd_pkg.sv ====
// Shared constants and types for the command/address bus controller
`default_nettype none
package lcacd_pkg;

  // ----------------------------------------------------------------
  // Command codes on lanes 4..0 (activate codes on lanes 1..0) of the first capture edge
  // ----------------------------------------------------------------
  localparam logic [4:0] CODE_MODE_WR_1 = 5'h06; // Mode write, part one
  localparam logic [4:0] CODE_MODE_WR_2 = 5'h16; // Mode write, part two
  localparam logic [4:0] CODE_MODE_RD_1 = 5'h0e; // Mode read, part one
  localparam logic [4:0] CODE_REFRESH   = 5'h08; // Refresh
  localparam logic [4:0] CODE_SR_ENTER  = 5'h18; // Self-refresh entry
  localparam logic [4:0] CODE_SR_EXIT   = 5'h14; // Self-refresh exit
  localparam logic [4:0] CODE_WRITE_1   = 5'h04; // Write, part one
  localparam logic [4:0] CODE_MWRITE_1  = 5'h0c; // Masked write, part one
  localparam logic [4:0] CODE_READ_1    = 5'h02; // Read, part one
  localparam logic [4:0] CODE_CAS_2     = 5'h12; // Column second half
  localparam logic [4:0] CODE_PRECHARGE = 5'h10; // Precharge
  localparam logic [4:0] CODE_MPC       = 5'h00; // Multipurpose command
  localparam logic [1:0] CODE_ACT_1     = 2'h1;  // Activate one, lanes 1..0
  localparam logic [1:0] CODE_ACT_2     = 2'h3;  // Activate two, lanes 1..0

  // ----------------------------------------------------------------
  // Device mode register map
  // ----------------------------------------------------------------
  localparam logic [5:0] MR_TEST_SCRATCH_MODE   = 6'h27; // Ignored by device
  localparam logic [5:0] MR_CAL_PATTERN_SECOND  = 6'h28; // Pattern byte two
  localparam logic [7:0] CAL_PATTERN_SECOND_RST = 8'h3c; // Its reset value
  localparam logic [5:0] MR_DO_NOT_USE_FIRST    = 6'h29; // Forbidden start
  localparam logic [5:0] MR_FUTURE_RSVD_FIRST   = 6'h30; // Reserved start
  localparam logic [5:0] MR_FUTURE_RSVD_LAST    = 6'h3f; // Reserved end
  localparam logic [5:0] MR_CAL_PATTERN_FIRST   = 6'h20; // Pattern byte one
  localparam logic [7:0] CAL_PATTERN_FIRST_RST  = 8'h5a; // Its reset value
  localparam logic [5:0] MR_LOWER_INVERT        = 6'h0f; // Lanes 7..0 mask
  localparam logic [5:0] MR_UPPER_INVERT        = 6'h14; // Lanes 15..8 mask
  localparam logic [5:0] MR_IO_CONFIG           = 6'h03; // I/O config register
  localparam int         IO_CFG_RD_INV_BIT      = 6;     // Read inversion bit
  localparam logic [6:0] MPC_READ_CAL           = 7'h43; // Read calibration op

  // ----------------------------------------------------------------
  // Timing counts in core clock cycles
  // ----------------------------------------------------------------
  localparam int MR_GAP_CYC     = 4;  // Idle cycles after a mode access
  localparam int RESET_HOLD_CYC = 16; // Device reset pin low time

  // ----------------------------------------------------------------
  // User command kinds
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    K_MODE_WRITE,
    K_MODE_READ,
    K_REFRESH,
    K_PRECHARGE,
    K_SR_ENTER,
    K_SR_EXIT,
    K_ACTIVATE,
    K_WRITE,
    K_MASK_WRITE,
    K_READ,
    K_MPC
  } lcacd_kind_e;

endpackage
`default_nettype wire

// ==== dv/lcacd_dev_model.sv ====
// Behavioural device that captures, decodes and keeps its mode registers
`timescale 1ns/1ns
`default_nettype none
module lcacd_dev_model (
  // Device pins
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_cs,
  input  wire logic [5:0]  i_ca,
  input  wire logic        i_cke,
  // Observation
  output logic             o_pair,
  output logic [11:0]      o_words,
  output logic [7:0]       o_cal_b,
  output logic             o_bad,
  // Read calibration lanes
  output logic             o_cal_act,
  output logic [15:0]      o_dq,
  output logic [1:0]       o_dmi,
  output logic             o_dmi_drv
);
  // ------------------------------------------------------------
  // Two-edge capture and decode
  // ------------------------------------------------------------
  logic       half_q; // Second capture edge pending
  logic [5:0] w0_q;   // First half lanes
  logic [6:0]  mra_q;    // Pending mode write OP7 and address
  logic [7:0]  mw;       // Data carried by mode write part two
  logic [7:0]  cal_a_q;  // Pattern byte one
  logic [15:0] inv_q;    // Lane invert masks, upper and lower
  logic        rd_inv_q; // Read bus inversion enabled
  logic [15:0] shf_q;    // Pattern bits still to go out
  logic [4:0]  cal_n_q;  // Count of pattern bits still to go out

  assign mw = {mra_q[6], w0_q[5], i_ca};

  // Capture, decode, pattern byte two, protocol flags
  always_ff @(posedge i_clk) begin
    o_pair <= 1'b0;
    if (!i_reset_n) begin
      half_q  <= 1'b0;
      o_cal_b <= lcacd_pkg::CAL_PATTERN_SECOND_RST;
      o_bad   <= 1'b0;
      cal_a_q  <= lcacd_pkg::CAL_PATTERN_FIRST_RST;
      inv_q    <= 16'h0000;
      rd_inv_q <= 1'b0;
    end else if (half_q) begin
      // Decode only once both halves are in
      half_q  <= 1'b0;
      o_pair  <= 1'b1;
      o_words <= {w0_q, i_ca};
      // Chip select must be low on the second edge
      if (i_cs) o_bad <= 1'b1;
      if (w0_q[4:0] == lcacd_pkg::CODE_MODE_WR_1) mra_q <= {w0_q[5], i_ca};
      // Part two lands in its register; scratch has no effect
      if (w0_q[4:0] == lcacd_pkg::CODE_MODE_WR_2) begin
        if (mra_q[5:0] == lcacd_pkg::MR_CAL_PATTERN_SECOND) begin
          o_cal_b <= mw;
        end else if (mra_q[5:0] == lcacd_pkg::MR_CAL_PATTERN_FIRST) begin
          cal_a_q <= mw;
        end else if (mra_q[5:0] == lcacd_pkg::MR_LOWER_INVERT) begin
          inv_q[7:0] <= mw;
        end else if (mra_q[5:0] == lcacd_pkg::MR_UPPER_INVERT) begin
          inv_q[15:8] <= mw;
        end else if (mra_q[5:0] == lcacd_pkg::MR_IO_CONFIG) begin
          rd_inv_q <= mw[lcacd_pkg::IO_CFG_RD_INV_BIT];
        end
      end
      // Reserved encodings flagged, no array action
      if (w0_q[4:0] inside {5'h1c, 5'h0a, 5'h1a}) o_bad <= 1'b1;
    end else if (i_cs) begin
      // Deselect cycles never start a command
      half_q <= 1'b1;
      w0_q   <= i_ca;
      // Clock enable must be high while commanding
      if (!i_cke) o_bad <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Read calibration stream
  // ------------------------------------------------------------
  // Byte one then byte two, one bit a cycle, low-order bit first
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      shf_q   <= 16'h0000;
      cal_n_q <= 5'h00;
    end else if (half_q && (w0_q[4:0] == lcacd_pkg::CODE_MPC) &&
                 ({w0_q[5], i_ca} == lcacd_pkg::MPC_READ_CAL)) begin
      shf_q   <= {o_cal_b, cal_a_q};
      cal_n_q <= 5'h10;
    end else if (cal_n_q != 5'h00) begin
      shf_q   <= {1'b0, shf_q[15:1]};
      cal_n_q <= cal_n_q - 5'h01;
    end
  end

  // Masks touch data lanes only; no bus inversion coding applied
  assign o_cal_act = (cal_n_q != 5'h00);
  assign o_dq      = {16{shf_q[0]}} ^ inv_q;
  assign o_dmi     = rd_inv_q ? {2{shf_q[0]}} : 2'b00;
  assign o_dmi_drv = rd_inv_q && o_cal_act;
endmodule
`default_nettype wire

// ==== dv/lcacd_ctrl_tb_top.sv ====
// Self-checking bench for the command/address bus controller
`timescale 1ns/1ns
`default_nettype none
module lcacd_ctrl_tb_top;
  // ------------------------------------------------------------
  // Stimulus and observation
  // ------------------------------------------------------------
  localparam int GAP  = 2; // Shortened mode access gap
  localparam int HOLD = 4; // Shortened device reset hold
  logic clk = 1'b0, rst_n = 1'b0, vld = 1'b0;
  lcacd_pkg::lcacd_kind_e kind = lcacd_pkg::K_REFRESH;
  logic [2:0]  bank = 3'h5;
  logic [16:0] row = 17'h1a5c3;
  logic [9:0]  col = 10'h3ff;
  logic [5:0]  ma = 6'h00;
  logic [7:0]  op = 8'h00;
  logic ab = 1'b0, bl = 1'b1, ap = 1'b1, mcas = 1'b0;
  logic rreq = 1'b0, idone = 1'b0;
  logic rdy, refd, ireq, cs, cke, dres_n, pair, bad;
  logic [5:0]  ca;
  logic [11:0] words;
  logic [7:0]  cal_b;
  logic        cact, cdrv;
  logic [1:0]  cdmi;
  logic [15:0] cdq;
  logic [18:0] cal_q[$];
  logic [11:0] got_q[$], exp_q[$];
  int failures = 0, n_tests = 0, gap, gap_mw;
  lcacd_pkg::lcacd_kind_e rw_k[3] = '{lcacd_pkg::K_WRITE,
    lcacd_pkg::K_MASK_WRITE, lcacd_pkg::K_READ};
  logic [4:0] rw_c[3] = '{lcacd_pkg::CODE_WRITE_1,
    lcacd_pkg::CODE_MWRITE_1, lcacd_pkg::CODE_READ_1};
  logic [5:0] rsv[4] = '{6'h29, 6'h2f, 6'h30, 6'h3f};

  // Free-running core clock, 8 ns period
  always #4 clk = ~clk;

  lcacd_ctrl #(.MR_GAP(GAP), .RESET_HOLD(HOLD)) i_dut (
    .I_CORE_CLK(clk), .I_RESETN(rst_n), .I_CMD_VALID(vld),
    .I_CMD_KIND(kind), .I_BANK(bank), .I_ROW(row), .I_COL(col),
    .I_MR_ADDR(ma), .I_OP(op), .I_ALL_BANK(ab), .I_BL32(bl),
    .I_AUTO_PRE(ap), .I_MPC_CAS(mcas), .O_CMD_READY(rdy),
    .O_CMD_REFUSED(refd), .I_RESET_REQ(rreq), .I_INIT_DONE(idone),
    .O_INIT_REQ(ireq), .O_CS(cs), .O_CA(ca), .O_CKE(cke),
    .O_DEV_RESET_N(dres_n));

  lcacd_dev_model i_dev (
    .i_clk(clk), .i_reset_n(dres_n), .i_cs(cs), .i_ca(ca),
    .i_cke(cke), .o_pair(pair), .o_words(words), .o_cal_b(cal_b),
    .o_bad(bad), .o_cal_act(cact), .o_dq(cdq), .o_dmi(cdmi),
    .o_dmi_drv(cdrv));

  // Collect every decoded command pair
  always @(posedge clk) begin
    if (pair === 1'b1) got_q.push_back(words);
    if (cact === 1'b1) cal_q.push_back({cdrv, cdmi, cdq});
  end

  // Verdict and end of run
  task automatic stop_test;
    $display("failures=%0d n_tests=%0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Compare one value
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Issue one command and check the pairs seen by the device
  task automatic send(input lcacd_pkg::lcacd_kind_e k, input logic refuse);
    int n;
    n = 0;
    got_q.delete();
    kind = k;
    vld = 1'b1;
    while (rdy !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    vld = 1'b0;
    cmp(refd, refuse);
    gap = 1;
    while (rdy !== 1'b1 && gap < 200) begin
      @(negedge clk);
      gap++;
    end
    repeat (3) @(negedge clk);
    cmp(got_q.size(), exp_q.size());
    foreach (exp_q[i]) begin
      if (i < got_q.size()) cmp(got_q[i], exp_q[i]);
    end
    exp_q.delete();
  endtask

  // Mode write with its two expected lane pairs
  task automatic mrw(input logic [5:0] a, input logic [7:0] d);
    ma = a;
    op = d;
    exp_q = '{{d[7], lcacd_pkg::CODE_MODE_WR_1, a},
      {d[6], lcacd_pkg::CODE_MODE_WR_2, d[5:0]}};
    send(lcacd_pkg::K_MODE_WRITE, 1'b0);
  endtask

  // Start read calibration and check every lane bit by bit
  task automatic cal_run(input logic [15:0] msk, input logic inv);
    logic [15:0] pat;
    pat = {8'ha5, lcacd_pkg::CAL_PATTERN_FIRST_RST};
    op = {1'b0, lcacd_pkg::MPC_READ_CAL};
    mcas = 1'b1;
    exp_q = '{{op[6], lcacd_pkg::CODE_MPC, op[5:0]},
      {col[8], lcacd_pkg::CODE_CAS_2, col[7:2]}};
    cal_q.delete();
    send(lcacd_pkg::K_MPC, 1'b0);
    repeat (20) @(negedge clk);
    cmp(cal_q.size(), 16);
    for (int i = 0; i < 16; i++) begin
      if (i < cal_q.size()) cmp(cal_q[i], {inv, inv ? {2{pat[i]}} : 2'b00,
        {16{pat[i]}} ^ msk});
    end
  endtask

  // Main sequence
  initial begin
    repeat (2) @(negedge clk);
    cmp({dres_n, cke, ireq}, 3'b001);
    rst_n = 1'b1;
    repeat (HOLD + 3) @(negedge clk);
    cmp({dres_n, cke, cal_b}, {2'b11, 8'h3c});
    idone = 1'b1;
    @(negedge clk);
    idone = 1'b0;
    cmp(ireq, 1'b0);
    // Mode write to pattern byte two, then to scratch
    ma = 6'h28;
    op = 8'ha5;
    exp_q = '{{6'h26, 6'h28}, {6'h16, 6'h25}};
    send(lcacd_pkg::K_MODE_WRITE, 1'b0);
    gap_mw = gap;
    cmp(cal_b, 8'ha5);
    ma = 6'h27;
    op = 8'h5a;
    exp_q = '{{6'h06, 6'h27}, {6'h36, 6'h1a}};
    send(lcacd_pkg::K_MODE_WRITE, 1'b0);
    cmp(gap, gap_mw);
    cmp(cal_b, 8'ha5);
    exp_q = '{{row[15:12], lcacd_pkg::CODE_ACT_1, row[11], row[10],
      row[16], bank}, {row[9:6], lcacd_pkg::CODE_ACT_2, row[5:0]}};
    send(lcacd_pkg::K_ACTIVATE, 1'b0);
    cmp(gap_mw - gap, GAP);
    for (int i = 0; i < 4; i++) begin
      ab = i[0];
      exp_q = '{{ab, i[1] ? lcacd_pkg::CODE_PRECHARGE :
        lcacd_pkg::CODE_REFRESH, 3'h0, bank}};
      send(i[1] ? lcacd_pkg::K_PRECHARGE : lcacd_pkg::K_REFRESH, 1'b0);
    end
    exp_q = '{{1'b0, lcacd_pkg::CODE_SR_ENTER, 6'h00}};
    send(lcacd_pkg::K_SR_ENTER, 1'b0);
    exp_q = '{{1'b0, lcacd_pkg::CODE_SR_EXIT, 6'h00}};
    send(lcacd_pkg::K_SR_EXIT, 1'b0);
    bank = 3'h6;
    for (int i = 0; i < 3; i++) begin
      bl = (i != 0);
      ap = i[0];
      exp_q = '{{bl & (i != 1), rw_c[i], ap, col[9], 1'b0, bank},
        {col[8], lcacd_pkg::CODE_CAS_2, col[7:4],
        (i == 2) ? col[3:2] : 2'b00}};
      send(rw_k[i], 1'b0);
    end
    ma = 6'h28;
    exp_q = '{{1'b0, lcacd_pkg::CODE_MODE_RD_1, 6'h28},
      {col[8], lcacd_pkg::CODE_CAS_2, col[7:2]}};
    send(lcacd_pkg::K_MODE_READ, 1'b0);
    col = 10'h2a8;
    cal_run(16'h0000, 1'b0);
    mrw(lcacd_pkg::MR_LOWER_INVERT, 8'h96);
    mrw(lcacd_pkg::MR_UPPER_INVERT, 8'h3c);
    mrw(lcacd_pkg::MR_IO_CONFIG, 8'h40);
    cal_run(16'h3c96, 1'b1);
    op = 8'h4d;
    mcas = 1'b0;
    exp_q = '{{op[6], lcacd_pkg::CODE_MPC, op[5:0]}};
    send(lcacd_pkg::K_MPC, 1'b0);
    for (int i = 0; i < 8; i++) begin
      ma = rsv[i[1:0]];
      send(i[2] ? lcacd_pkg::K_MODE_READ : lcacd_pkg::K_MODE_WRITE, 1'b1);
    end
    cmp(bad, 1'b0);
    // Recovery restarts the device and owes an init sequence
    rreq = 1'b1;
    @(negedge clk);
    rreq = 1'b0;
    cmp({ireq, dres_n}, 2'b10);
    repeat (HOLD + 3) @(negedge clk);
    cmp({dres_n, cke, cal_b}, {2'b11, 8'h3c});
    idone = 1'b1;
    @(negedge clk);
    idone = 1'b0;
    cmp(ireq, 1'b0);
    stop_test();
  end

  // Watchdog against a hang
  initial begin
    #100000;
    failures++;
    stop_test();
  end
endmodule
`default_nettype wire
